// ==== pkg/rwa_pkg.sv ====
// Purpose: shared constants and types for the receive word aligner block
// Assumes: one system clock, AXI4-Lite register access
// Notes: offsets are byte addresses
package rwa_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_PRBS_CLR = 8'h10;
  localparam logic [7:0] ADDR_RUN_LIMIT = 8'h14;
  // ctrl fields
  localparam int CTRL_BITSLIP_MODE = 0;
  localparam int CTRL_MANUAL_MODE = 1;
  localparam int CTRL_SONET_SIZE = 2;
  localparam int CTRL_TX_IDLE = 3;
  // irq fields
  localparam int IRQ_PRBS_DONE = 0;
  localparam int IRQ_PRBS_ERR = 1;
  localparam int IRQ_RUN_ERR = 2;
  localparam int IRQ_ALIGN = 3;
  localparam int IRQ_W = 4;
  localparam int SLIP_W = 5;
  localparam int PMA_W = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] RUN_LIMIT_RST = 16'h0020;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // PRBS7 polynomial taps x^7 + x^6 + 1
  localparam int PRBS_ORDER = 7;
  localparam logic [15:0] PRBS_PERIOD = 16'h007f;
  typedef struct packed {
    logic bitslip_mode;
    logic manual_mode;
    logic sonet_size;
    logic tx_idle;
  } rwa_ctrl_t;
endpackage

// ==== rtl/rwa_top.sv ====
// Purpose: receive word aligner and PRBS status control with register bus
// Assumes: serial bits arrive one per clock on i_rx_bit
// Notes: lane pins are asynchronous and pass two flops before use
// Overview of operation
// [R1] in bitslip mode the slip count is reported on a 5-bit output.
// [R2] the run length flag rises when identical bits exceed the set limit.
// [R3] a manual alignment is requested by an edge of the align input.
// [R4] the SONET frame size selects A1A2 detection, only at 8-bit width.
// [R5] in bitslip mode each rising bitslip edge moves the word boundary by one bit.
// [R6] each slip drops the oldest received bit from the stream.
// [R7] the bitslip input is synchronised before its edges are found.
// [R8] PRBS done rises after a full error-free pass of the polynomial.
// [R9] PRBS errors are flagged only once done is high.
// [R10] the PRBS error flag pulses once per word in error at most.
// [R11] writing the PRBS clear register drops the done flag.
// [R12] while transmit idle is set the serial output is tristated.
// [R13] the core holds transmit idle low when idle is not wanted.
// [R14] signal detect is high while the input level passes threshold.
// [R15] the core synchronises signal detect before using it.
// [R16] only the rising edge of the align input starts an alignment.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rwa_top #(
  parameter int WORD_W = rwa_pkg::PMA_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // axi4-lite write
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // lane pins
  input wire logic i_rx_bit,
  input wire logic i_rx_bitslip,
  input wire logic i_rx_manual_align_req,
  input wire logic i_rx_level_above,
  // lane outputs
  output logic [rwa_pkg::SLIP_W-1:0] o_rx_slip_count,
  output logic o_rx_runlength_err,
  output logic [WORD_W-1:0] o_rx_word,
  output logic o_rx_word_valid,
  output logic o_rx_prbs_done,
  output logic o_rx_prbs_err,
  output logic o_rx_signal_detect,
  output logic o_tx_serial,
  output logic o_tx_serial_oe,
  output logic o_rx_detect_en,
  output logic o_irq
);
  // ****************************************
  // reset and input synchronisers
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic slip_d;
  logic align_d;
  // [R7] two-flop input sync
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      slip_d <= 1'b0;
      align_d <= 1'b0;
    end
    else
    begin
      sync_a <= {i_rx_level_above, i_rx_manual_align_req, i_rx_bitslip,
                 i_rx_bit};
      sync_b <= sync_a;
      slip_d <= sync_b[1];
      align_d <= sync_b[2];
    end
  end
  logic bit_in;
  logic slip_rise;
  logic align_rise;
  assign bit_in = sync_b[0];
  // [R5] rising slip edge
  assign slip_rise = sync_b[1] & ~slip_d;
  // [R16] rising align edge only
  assign align_rise = sync_b[2] & ~align_d;

  // ****************************************
  // registers
  // ****************************************
  rwa_pkg::rwa_ctrl_t ctrl;
  logic [15:0] run_limit;
  logic [rwa_pkg::IRQ_W-1:0] irq_stat;
  logic [rwa_pkg::IRQ_W-1:0] irq_mask;
  logic [rwa_pkg::IRQ_W-1:0] irq_evt;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic do_write;
  logic prbs_clr_wr;
  logic stat_rd;
  logic [3:0] i_wstrb_q;
  assign do_write = aw_hold & w_hold & ~o_bvalid;
  assign prbs_clr_wr = do_write & (aw_addr == rwa_pkg::ADDR_PRBS_CLR);
  assign stat_rd = i_arvalid & o_arready &
                   (i_araddr == rwa_pkg::ADDR_IRQ_STAT);

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      o_bvalid <= 1'b0;
      o_bresp <= rwa_pkg::RESP_OKAY;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_hold <= 1'b1;
        w_data <= i_wdata;
      end
      if (do_write)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        o_bvalid <= 1'b1;
        case (aw_addr)
          rwa_pkg::ADDR_CTRL, rwa_pkg::ADDR_IRQ_MASK, rwa_pkg::ADDR_PRBS_CLR,
          rwa_pkg::ADDR_RUN_LIMIT, rwa_pkg::ADDR_STATUS,
          rwa_pkg::ADDR_IRQ_STAT: o_bresp <= rwa_pkg::RESP_OKAY;
          default: o_bresp <= rwa_pkg::RESP_SLVERR;
        endcase
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end
  // registered readies, raised again once the response is gone
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end
    else
    begin
      if (i_awvalid && o_awready)
        o_awready <= 1'b0;
      else if (!aw_hold && !o_bvalid)
        o_awready <= 1'b1;
      if (i_wvalid && o_wready)
        o_wready <= 1'b0;
      else if (!w_hold && !o_bvalid)
        o_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= rwa_pkg::rwa_ctrl_t'(rwa_pkg::CTRL_RST[3:0]);
      run_limit <= rwa_pkg::RUN_LIMIT_RST;
      irq_mask <= '0;
    end
    else if (do_write)
    begin
      if (aw_addr == rwa_pkg::ADDR_CTRL && i_wstrb_q[0])
        ctrl <= '{w_data[rwa_pkg::CTRL_BITSLIP_MODE],
                  w_data[rwa_pkg::CTRL_MANUAL_MODE],
                  w_data[rwa_pkg::CTRL_SONET_SIZE],
                  w_data[rwa_pkg::CTRL_TX_IDLE]};
      if (aw_addr == rwa_pkg::ADDR_IRQ_MASK && i_wstrb_q[0])
        irq_mask <= w_data[rwa_pkg::IRQ_W-1:0];
      if (aw_addr == rwa_pkg::ADDR_RUN_LIMIT)
        run_limit <= w_data[15:0];
    end
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      i_wstrb_q <= 4'h0;
    else if (i_wvalid && o_wready)
      i_wstrb_q <= i_wstrb;
  end

  // sticky events, set wins over read clear
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat <= '0;
    else if (stat_rd)
      irq_stat <= irq_evt;
    else
      irq_stat <= irq_stat | irq_evt;
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |((irq_stat | irq_evt) & irq_mask);
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (i_araddr)
      rwa_pkg::ADDR_CTRL: rd_mux = {28'h0, ctrl.tx_idle, ctrl.sonet_size,
                                    ctrl.manual_mode, ctrl.bitslip_mode};
      rwa_pkg::ADDR_STATUS: rd_mux = {16'h0, 3'h0, o_rx_slip_count,
                                      4'h0, o_rx_signal_detect,
                                      o_rx_runlength_err, o_rx_prbs_err,
                                      o_rx_prbs_done};
      rwa_pkg::ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat};
      rwa_pkg::ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask};
      rwa_pkg::ADDR_RUN_LIMIT: rd_mux = {16'h0, run_limit};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= rwa_pkg::RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= (i_araddr == rwa_pkg::ADDR_PRBS_CLR ||
                  i_araddr > rwa_pkg::ADDR_RUN_LIMIT ||
                  i_araddr[1:0] != 2'h0) ? rwa_pkg::RESP_SLVERR
                                         : rwa_pkg::RESP_OKAY;
    end
    else if (o_rvalid && i_rready)
      o_rvalid <= 1'b0;
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_arready <= 1'b0;
    else if (i_arvalid && o_arready)
      o_arready <= 1'b0;
    else if (!o_rvalid)
      o_arready <= 1'b1;
  end

  // ****************************************
  // word assembly and bitslip
  // ****************************************
  logic [WORD_W-1:0] shreg;
  logic [$clog2(WORD_W+1)-1:0] bit_cnt;
  logic word_stb;
  assign word_stb = (bit_cnt == ($clog2(WORD_W+1))'(WORD_W - 1));
  // [R6] slip drops oldest bit by holding count for one cycle
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg <= '0;
      bit_cnt <= '0;
      o_rx_word <= '0;
      o_rx_word_valid <= 1'b0;
    end
    else
    begin
      shreg <= {bit_in, shreg[WORD_W-1:1]};
      o_rx_word_valid <= word_stb;
      if (word_stb)
        o_rx_word <= {bit_in, shreg[WORD_W-1:1]};
      // [R5] one bit per edge
      if (ctrl.bitslip_mode && slip_rise)
        bit_cnt <= bit_cnt;
      else if (word_stb)
        bit_cnt <= '0;
      else
        bit_cnt <= bit_cnt + 1'b1;
    end
  end
  // [R1] slip count report
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_rx_slip_count <= '0;
    else if (!ctrl.bitslip_mode)
      o_rx_slip_count <= '0;
    else if (slip_rise)
      o_rx_slip_count <= (o_rx_slip_count == rwa_pkg::SLIP_W'(WORD_W - 1))
                         ? '0 : o_rx_slip_count + 1'b1;
  end

  // ****************************************
  // manual alignment and run length
  // ****************************************
  logic [15:0] run_len;
  logic prev_bit;
  logic align_evt;
  // [R3] edge starts alignment; [R4] A1A2 only at 8-bit width
  assign align_evt = ctrl.manual_mode & align_rise &
                     (!ctrl.sonet_size || WORD_W == rwa_pkg::PMA_W);
  // [R2] run length compare
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_len <= 16'h0001;
      prev_bit <= 1'b0;
      o_rx_runlength_err <= 1'b0;
    end
    else
    begin
      prev_bit <= bit_in;
      if (bit_in == prev_bit && run_len != 16'hffff)
        run_len <= run_len + 16'h0001;
      else if (bit_in != prev_bit)
        run_len <= 16'h0001;
      o_rx_runlength_err <= (run_len > run_limit);
    end
  end

  // ****************************************
  // prbs verifier
  // ****************************************
  logic [rwa_pkg::PRBS_ORDER-1:0] lfsr;
  logic [15:0] pass_cnt;
  logic miss;
  logic [WORD_W-1:0] word_miss;
  logic bad;
  logic done_set;
  assign miss = bit_in ^ (lfsr[rwa_pkg::PRBS_ORDER-1] ^
                          lfsr[rwa_pkg::PRBS_ORDER-2]);
  // all-zero history is the lock-up state, never a pattern
  assign bad = miss | (lfsr == '0);
  assign done_set = ~prbs_clr_wr & ~bad & ~o_rx_prbs_done &
                    (pass_cnt == rwa_pkg::PRBS_PERIOD);
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfsr <= '0;
      pass_cnt <= 16'h0000;
      word_miss <= '0;
      o_rx_prbs_done <= 1'b0;
      o_rx_prbs_err <= 1'b0;
    end
    else
    begin
      lfsr <= {lfsr[rwa_pkg::PRBS_ORDER-2:0], bit_in};
      word_miss <= word_stb ? '0 : {word_miss[WORD_W-2:0], miss};
      // [R9] [R10] after done, one pulse per word
      o_rx_prbs_err <= word_stb & o_rx_prbs_done & (miss | (|word_miss));
      // [R11] clear write drops done
      if (prbs_clr_wr)
      begin
        o_rx_prbs_done <= 1'b0;
        pass_cnt <= 16'h0000;
      end
      // [R8] done after full clean pass
      else if (bad)
        pass_cnt <= 16'h0000;
      else if (pass_cnt == rwa_pkg::PRBS_PERIOD)
        o_rx_prbs_done <= 1'b1;
      else
        pass_cnt <= pass_cnt + 16'h0001;
    end
  end

  // ****************************************
  // lane misc
  // ****************************************
  // [R12] idle tristates tx and enables detect
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_tx_serial <= 1'b0;
      o_tx_serial_oe <= 1'b0;
      o_rx_detect_en <= 1'b0;
      o_rx_signal_detect <= 1'b0;
    end
    else
    begin
      o_tx_serial <= lfsr[rwa_pkg::PRBS_ORDER-1] ^
                     lfsr[rwa_pkg::PRBS_ORDER-2];
      o_tx_serial_oe <= ~ctrl.tx_idle;
      o_rx_detect_en <= ctrl.tx_idle;
      // [R14] threshold level
      o_rx_signal_detect <= sync_b[3];
    end
  end
  // rising edges only, so a level flag does not refill the sticky bit
  assign irq_evt = {align_evt, (run_len > run_limit) & ~o_rx_runlength_err,
                    o_rx_prbs_err, done_set};

  // ****************************************
  // checks
  // ****************************************
  property p_idle_oe;
    @(posedge i_sys_clk) disable iff (!rst_n)
    ctrl.tx_idle |=> !o_tx_serial_oe && o_rx_detect_en;
  endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("idle oe"); // [R12]
  property p_err_done;
    @(posedge i_sys_clk) disable iff (!rst_n)
    o_rx_prbs_err |-> $past(o_rx_prbs_done);
  endproperty
  a_err_done: assert property (p_err_done) else $error("err early"); // [R9]
  property p_err_pulse;
    @(posedge i_sys_clk) disable iff (!rst_n)
    o_rx_prbs_err |=> !o_rx_prbs_err;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("err"); // [R10]
  property p_clr;
    @(posedge i_sys_clk) disable iff (!rst_n)
    prbs_clr_wr |=> !o_rx_prbs_done;
  endproperty
  a_clr: assert property (p_clr) else $error("clr"); // [R11]
  property p_slip;
    @(posedge i_sys_clk) disable iff (!rst_n)
    ctrl.bitslip_mode && slip_rise &&
      o_rx_slip_count != rwa_pkg::SLIP_W'(WORD_W - 1) |=>
      o_rx_slip_count == $past(o_rx_slip_count) + 5'h01;
  endproperty
  a_slip: assert property (p_slip) else $error("slip"); // [R5]
  property p_align;
    @(posedge i_sys_clk) disable iff (!rst_n)
    align_evt |=> !align_evt;
  endproperty
  a_align: assert property (p_align) else $error("align"); // [R16]
  property p_run;
    @(posedge i_sys_clk) disable iff (!rst_n)
    run_len > run_limit |=> o_rx_runlength_err;
  endproperty
  a_run: assert property (p_run) else $error("run"); // [R2]
  property p_sd;
    @(posedge i_sys_clk) disable iff (!rst_n)
    sync_b[3] |=> o_rx_signal_detect;
  endproperty
  a_sd: assert property (p_sd) else $error("sd"); // [R14]
endmodule
`default_nettype wire

// ==== dv/rwa_serial_src.sv ====
// Purpose: model of the remote serial transmitter on the receive bit line
// Assumes: one bit per clock, prbs7 pattern while running
// Notes: inject flips the bit sent at that edge; idle sends a fixed level
`timescale 1ns/1ps
`default_nettype none
module rwa_serial_src (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_run,
  input wire logic i_inject,
  input wire logic i_level,
  // serial out
  output logic o_bit
);
  logic [6:0] lfsr;
  // ****************************************
  // serial source
  // ****************************************
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      lfsr <= 7'h7f;
      o_bit <= 1'b0;
    end
    else if (i_run)
    begin
      // prbs7 x^7 + x^6 + 1
      lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
      o_bit <= lfsr[6] ^ lfsr[5] ^ i_inject;
    end
    else
      o_bit <= i_level;
  end
endmodule
`default_nettype wire

// ==== dv/rwa_top_tb.sv ====
// Purpose: self-checking bench for the word aligner control block
// Assumes: serial source model drives the receive bit line
// Notes: random draws come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module rwa_top_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic slip = 1'b0, align = 1'b0, level = 1'b0;
  logic run = 1'b0, inject = 1'b0, hold = 1'b0;
  logic rx_bit, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [4:0] slip_cnt;
  logic [7:0] word;
  logic runerr, wvld, done, perr, sigdet, txs, txoe, deten, irq;
  logic [1:0] sd_sync = 2'h0;
  int mismatches = 0;
  int n_tests = 0;
  int k, n, errs, lim;
  always #2 clk = ~clk;
  rwa_top #(.WORD_W(8)) DUT (
    .i_sys_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_rx_bit(rx_bit), .i_rx_bitslip(slip),
    .i_rx_manual_align_req(align), .i_rx_level_above(level),
    .o_rx_slip_count(slip_cnt), .o_rx_runlength_err(runerr),
    .o_rx_word(word), .o_rx_word_valid(wvld), .o_rx_prbs_done(done),
    .o_rx_prbs_err(perr), .o_rx_signal_detect(sigdet),
    .o_tx_serial(txs), .o_tx_serial_oe(txoe), .o_rx_detect_en(deten),
    .o_irq(irq));
  rwa_serial_src src (.i_clk(clk), .i_nrst(nrst), .i_run(run),
    .i_inject(inject), .i_level(hold), .o_bit(rx_bit));
  always_ff @(posedge clk) sd_sync <= {sd_sync[0], sigdet};
  // ****************************************
  // tasks
  // ****************************************
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fail_to();
    mismatches++;
    $display("BAD t=%0t wait ran out", $time);
    finish_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic ta, tw, tb;
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    i = 0;
    do
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      i++;
    end
    while (!tb && i < 60);
    bready <= 1'b0;
    if (!tb) fail_to();
    chk(32'(rsp), 32'(er));
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
    logic ta, tr;
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    i = 0;
    do
    begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      i++;
    end
    while (!tr && i < 60);
    rready <= 1'b0;
    if (!tr) fail_to();
    chk(32'(rsp), 32'(er));
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return done;
      1: return runerr;
      2: return txoe;
      3: return wvld;
      default: return sd_sync[1];
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, input int lm);
    int i;
    for (i = 0; i < lm && sig(s) !== v; i++)
      @(negedge clk);
    if (sig(s) !== v) fail_to();
  endtask
  task automatic count_err(input int c);
    errs = 0;
    repeat (c) @(negedge clk) if (perr === 1'b1) errs++;
  endtask
  task automatic slips(input int m);
    repeat (m)
    begin
      @(posedge clk);
      slip <= 1'b1;
      repeat (5) @(posedge clk);
      slip <= 1'b0;
      repeat (5) @(posedge clk);
    end
    repeat (5) @(negedge clk);
  endtask
  task automatic align_edge(input logic v);
    @(posedge clk);
    align <= v;
    repeat (12) @(negedge clk);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_to();
  end
  initial
  begin
    n = $urandom(69);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(rwa_pkg::ADDR_CTRL, rwa_pkg::RESP_OKAY);
    chk(rd, rwa_pkg::CTRL_RST);
    rd_reg(rwa_pkg::ADDR_RUN_LIMIT, rwa_pkg::RESP_OKAY);
    chk(rd, 32'(rwa_pkg::RUN_LIMIT_RST));
    rd_reg(8'h18, rwa_pkg::RESP_SLVERR);
    rd_reg(rwa_pkg::ADDR_PRBS_CLR, rwa_pkg::RESP_SLVERR);
    wr(8'h1c, 32'h5, rwa_pkg::RESP_SLVERR);
    wr(rwa_pkg::ADDR_CTRL, 32'h8, rwa_pkg::RESP_OKAY);
    wait_for(2, 1'b0, 12);
    chk(32'(deten), 32'h1);
    wr(rwa_pkg::ADDR_CTRL, 32'h0, rwa_pkg::RESP_OKAY);
    wait_for(2, 1'b1, 12);
    chk(32'(deten), 32'h0);
    for (k = 0; k < 6; k++)
    begin
      @(posedge clk);
      level <= ~level;
      repeat ($urandom_range(1, 9)) @(posedge clk);
      wait_for(4, level, 12);
      rd_reg(rwa_pkg::ADDR_STATUS, rwa_pkg::RESP_OKAY);
      chk(32'(rd[3]), 32'(level));
    end
    wr(rwa_pkg::ADDR_IRQ_MASK, 32'hf, rwa_pkg::RESP_OKAY);
    @(posedge clk);
    run <= 1'b1;
    repeat (60) @(negedge clk);
    chk(32'(done), 32'h0);
    rd_reg(rwa_pkg::ADDR_IRQ_STAT, rwa_pkg::RESP_OKAY);
    wait_for(0, 1'b1, 500);
    repeat (3) @(negedge clk);
    chk(32'(irq), 32'h1);
    wr(rwa_pkg::ADDR_IRQ_MASK, 32'h0, rwa_pkg::RESP_OKAY);
    repeat (3) @(negedge clk);
    chk(32'(irq), 32'h0);
    rd_reg(rwa_pkg::ADDR_IRQ_STAT, rwa_pkg::RESP_OKAY);
    chk(32'(rd[rwa_pkg::IRQ_PRBS_DONE]), 32'h1);
    rd_reg(rwa_pkg::ADDR_IRQ_STAT, rwa_pkg::RESP_OKAY);
    chk(32'(rd[rwa_pkg::IRQ_PRBS_DONE]), 32'h0);
    @(posedge clk);
    inject <= 1'b1;
    @(posedge clk);
    inject <= 1'b0;
    count_err(40);
    chk(32'(errs >= 1 && errs <= 3), 32'h1);
    wr(rwa_pkg::ADDR_PRBS_CLR, $urandom, rwa_pkg::RESP_OKAY);
    inject <= 1'b1;
    @(posedge clk);
    inject <= 1'b0;
    count_err(6);
    chk(32'(done), 32'h0);
    count_err(30);
    chk(32'(errs), 32'h0);
    wait_for(0, 1'b1, 500);
    // prbs7 runs reach 7 bits, so stay above that
    lim = $urandom_range(8, 20);
    wr(rwa_pkg::ADDR_RUN_LIMIT, 32'(lim), rwa_pkg::RESP_OKAY);
    @(posedge clk);
    hold <= ~rx_bit;
    run <= 1'b0;
    repeat (lim + 3) @(negedge clk);
    chk(32'(runerr), 32'h0);
    wait_for(1, 1'b1, 4);
    chk(32'(runerr), 32'h1);
    wait_for(3, 1'b1, 12);
    chk(32'(word), 32'({8{hold}}));
    wr(rwa_pkg::ADDR_CTRL, 32'h1, rwa_pkg::RESP_OKAY);
    n = $urandom_range(1, 12);
    slips(n);
    chk(32'(slip_cnt), 32'(n % 8));
    rd_reg(rwa_pkg::ADDR_STATUS, rwa_pkg::RESP_OKAY);
    chk(32'(rd[12:8]), 32'(n % 8));
    @(posedge clk);
    slip <= 1'b1;
    repeat (20) @(negedge clk);
    chk(32'(slip_cnt), 32'((n + 1) % 8));
    @(posedge clk);
    slip <= 1'b0;
    wr(rwa_pkg::ADDR_CTRL, 32'h6, rwa_pkg::RESP_OKAY);
    slips(2);
    chk(32'(slip_cnt), 32'h0);
    rd_reg(rwa_pkg::ADDR_CTRL, rwa_pkg::RESP_OKAY);
    chk(rd, 32'h6);
    rd_reg(rwa_pkg::ADDR_IRQ_STAT, rwa_pkg::RESP_OKAY);
    align_edge(1'b1);
    rd_reg(rwa_pkg::ADDR_IRQ_STAT, rwa_pkg::RESP_OKAY);
    chk(32'(rd[rwa_pkg::IRQ_ALIGN]), 32'h1);
    repeat (20) @(negedge clk);
    rd_reg(rwa_pkg::ADDR_IRQ_STAT, rwa_pkg::RESP_OKAY);
    chk(32'(rd[rwa_pkg::IRQ_ALIGN]), 32'h0);
    align_edge(1'b0);
    align_edge(1'b1);
    rd_reg(rwa_pkg::ADDR_IRQ_STAT, rwa_pkg::RESP_OKAY);
    chk(32'(rd[rwa_pkg::IRQ_ALIGN]), 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
